/* File: dv/mcp_host_model.sv */
`default_nettype none

module mcp_host_model (
  input  wire logic                 core_clk,
  input  wire logic                 busy_r,
  input  wire logic [15:0]          io_rdata_r,
  input  wire logic                 io_rvalid_r,
  output var  mcp_pkg::mcp_io_req_s io_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Host I/O cycles, launched on the falling edge
  // ************************************************************
  initial io_req = '0;

  // Released lines flip so a stale value never looks valid
  task automatic idle_bus();
    io_req.strb  = 1'b0;
    io_req.addr  = ~io_req.addr;
    io_req.wdata = ~io_req.wdata;
  endtask : idle_bus

  // Operands come from the host only, never fetched by the block
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic b8);
    int n;
    n = 0;
    // Clear port bypasses the wait, it is what ends a latched stall
    while (busy_r !== 1'b0 && a != mcp_pkg::PORT_CLR && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    io_req = '{strb: 1'b1, wr: 1'b1, byte8: b8, addr: a, wdata: d};
    @(negedge core_clk);
    idle_bus();
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d,
                    output logic ok);
    @(negedge core_clk);
    io_req.strb = 1'b1;
    io_req.wr   = 1'b0;
    io_req.addr = a;
    @(negedge core_clk);
    idle_bus();
    ok = 1'b0;
    d  = 16'h0000;
    repeat (3)
    begin
      if (!ok && io_rvalid_r === 1'b1)
      begin
        ok = 1'b1;
        d  = io_rdata_r;
      end
      @(negedge core_clk);
    end
  endtask : rd
endmodule : mcp_host_model

`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none

`define CHK(g, e, m) \
  samples_checked++; \
  if ((g) !== (e)) \
  begin \
    err_count++; \
    $display("MISMATCH t=%0t %s", $time, m); \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 core_clk;
  logic                 rst_n;
  mcp_pkg::mcp_io_req_s io_req;
  logic [15:0]          io_rdata_r;
  logic                 io_rvalid_r;
  logic                 busy_r;
  logic                 error_r;
  logic                 irq13_r;
  int                   err_count;
  int                   samples_checked;
  int                   cycles;
  logic [15:0]          lfsr;
  int                   stk[$];
  int                   flags;
  logic                 err_m;
  logic [3:0]           ops[3];

  mcp_host_port dut (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .io_req      (io_req),
    .io_rdata_r  (io_rdata_r),
    .io_rvalid_r (io_rvalid_r),
    .busy_r      (busy_r),
    .error_r     (error_r),
    .irq13_r     (irq13_r)
  );

  mcp_host_model host (
    .core_clk    (core_clk),
    .busy_r      (busy_r),
    .io_rdata_r  (io_rdata_r),
    .io_rvalid_r (io_rvalid_r),
    .io_req      (io_req)
  );

  // ************************************************************
  // Clock, watchdog, verdict
  // ************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // Whole run is under a thousand cycles, so this only trips on a hang
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      err_count++;
      $display("MISMATCH t=%0t run timed out", $time);
      results();
    end
  end

  // ************************************************************
  // Reference model helpers
  // ************************************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [15:0] op(input logic [3:0] c);
    return {c, mcp_pkg::FMT_I16, 9'h000};
  endfunction : op

  task automatic run(input logic [15:0] c, input int exp);
    int n;
    int k;
    n = 0;
    host.wr(mcp_pkg::PORT_CMD, c, 1'b0);
    for (k = 0; k < 300 && (n == 0 || busy_r === 1'b1); k++)
    begin
      if (busy_r === 1'b1)
        n++;
      @(negedge core_clk);
    end
    `CHK(n, exp, "busy length")
  endtask : run

  // Full stack refuses the push and flags invalid
  task automatic load(input int v);
    host.wr(mcp_pkg::PORT_OPND, 16'(v), 1'b0);
    run(op(mcp_pkg::CMD_LOAD), 2);
    if (stk.size() == 8)
      flags |= 1;
    else
      stk.push_front(v);
  endtask : load

  task automatic chk_status();
    logic [15:0] d;
    logic        ok;
    logic [15:0] e;
    e = {2'b00, err_m, 4'(stk.size()), 3'(8 - stk.size()), 6'(flags)};
    host.rd(mcp_pkg::PORT_CMD, d, ok);
    `CHK({ok, d}, {1'b1, e}, "status word")
  endtask : chk_status

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    logic [15:0] d;
    logic        ok;
    int          a;
    int          b;
    int          e;
    rst_n = 1'b0;
    lfsr = 16'h003A;
    flags = 0;
    err_m = 1'b0;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    ops = '{mcp_pkg::CMD_ADD, mcp_pkg::CMD_SUB, mcp_pkg::CMD_DIV};
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    `CHK({busy_r, irq13_r, error_r}, 3'h0, "reset outputs")
    host.rd(mcp_pkg::PORT_OPND, d, ok);
    `CHK({ok, d}, {1'b1, 10'h000, mcp_pkg::MASK_RST}, "mask reset")
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      lfsr = lfsr_next(lfsr);
      b = (lfsr & 16'h7F) | 1;
      lfsr = lfsr_next(lfsr);
      a = (lfsr & 16'h7F) * b;
      load(b);
      load(a);
      // Top entry is the left operand
      e = (i % 3 == 0) ? stk[0] + stk[1] :
          (i % 3 == 1) ? stk[0] - stk[1] : stk[0] / stk[1];
      run(op(ops[i % 3]), (i % 3 == 2) ? 67 : 2);
      run(op(mcp_pkg::CMD_STORE), 2);
      stk.delete();
      host.rd(mcp_pkg::PORT_RES, d, ok);
      `CHK({ok, d}, {1'b1, 16'(e)}, "result low")
      host.rd(mcp_pkg::PORT_RES, d, ok);
      `CHK({ok, d}, {1'b1, 16'(e >>> 16)}, "result sign")
    end
    chk_status();
    $display("test arithmetic done");
    for (int i = 0; i < 9; i++)
      load(i);
    chk_status();
    `CHK(error_r, 1'b0, "masked invalid")
    $display("test overflow done");
    run(op(mcp_pkg::CMD_CLEX), 2);
    flags = 0;
    host.wr(mcp_pkg::PORT_OPND, 16'h0000, 1'b0);
    run(op(mcp_pkg::CMD_SETMASK), 2);
    host.wr(mcp_pkg::PORT_CMD, 16'hF000, 1'b0);
    flags = 1;
    err_m = 1'b1;
    repeat (10) @(negedge core_clk);
    `CHK({busy_r, error_r, irq13_r}, 3'h7, "error latch")
    host.wr(mcp_pkg::PORT_CLR, 16'h0000, 1'b0);
    host.wr(mcp_pkg::PORT_CLR, 16'h0001, 1'b1);
    repeat (2) @(negedge core_clk);
    `CHK({busy_r, irq13_r}, 2'h3, "bad clear ignored")
    host.wr(mcp_pkg::PORT_CLR, 16'h0000, 1'b1);
    repeat (2) @(negedge core_clk);
    `CHK({busy_r, error_r, irq13_r}, 3'h2, "clear write")
    chk_status();
    run(op(mcp_pkg::CMD_CLEX), 2);
    `CHK(error_r, 1'b0, "error cleared")
    $display("test error done");
    // Fixed set: R1 = R1 + R2, then read R1 back
    stk[1] = stk[1] + stk[2];
    run(op(mcp_pkg::CMD_ADD) | 16'h010A, 2);
    run(op(mcp_pkg::CMD_STORE) | 16'h0108, 2);
    host.rd(mcp_pkg::PORT_RES, d, ok);
    `CHK({ok, d}, {1'b1, 16'(stk[1])}, "fixed result")
    // R7 holds zero; unmasked zero divide latches busy
    host.wr(mcp_pkg::PORT_CMD, op(mcp_pkg::CMD_DIV) | 16'h010F, 1'b0);
    flags = 4;
    repeat (4) @(negedge core_clk);
    `CHK({busy_r, error_r, irq13_r}, 3'h7, "zero divide latch")
    host.rd(mcp_pkg::PORT_CMD, d, ok);
    `CHK({ok, d[5:0]}, {1'b1, 6'(flags)}, "zero divide flag")
    // Reset mid-run drops the latch without a clear write
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    `CHK({busy_r, error_r, irq13_r}, 3'h0, "latch after reset")
    stk.delete();
    flags = 0;
    err_m = 1'b0;
    chk_status();
    $display("test fixed and reset done");
    results();
  end
endmodule : testbench

`default_nettype wire

/* File: rtl/mcp_alu.sv */
`default_nettype none

module mcp_alu (
  input  wire mcp_pkg::mcp_cmd_e cmd,
  input  wire mcp_pkg::mcp_fmt_e fmt,
  input  wire logic [79:0]       opa,
  input  wire logic [79:0]       opb,
  input  wire logic [63:0]       quo,
  input  wire logic [63:0]       rem,
  input  wire logic              stk_bad,
  output logic      [79:0]       res,
  output logic      [5:0]        flags
);

  logic        is_int;
  logic        arith;
  logic        zdiv;
  logic [64:0] v65;

  // Signed range check at the operand's integer width
  function automatic logic fits(logic [64:0] v, mcp_pkg::mcp_fmt_e f);
    case (f)
      mcp_pkg::FMT_I16: fits = (&v[64:15]) | ~(|v[64:15]);
      mcp_pkg::FMT_I32: fits = (&v[64:31]) | ~(|v[64:31]);
      default:          fits = v[64] == v[63];
    endcase
  endfunction : fits

  function automatic logic denorm(logic [79:0] v, mcp_pkg::mcp_fmt_e f);
    case (f)
      mcp_pkg::FMT_R24: denorm = ~(|v[30:23]) & (|v[22:0]);
      mcp_pkg::FMT_R53: denorm = ~(|v[62:52]) & (|v[51:0]);
      mcp_pkg::FMT_R64: denorm = ~(|v[78:64]) & (|v[63:0]);
      default:          denorm = 1'b0;
    endcase
  endfunction : denorm

  always_comb
  begin
    is_int = fmt == mcp_pkg::FMT_I16 || fmt == mcp_pkg::FMT_I32 ||
             fmt == mcp_pkg::FMT_I64;
    arith  = cmd == mcp_pkg::CMD_ADD || cmd == mcp_pkg::CMD_SUB ||
             cmd == mcp_pkg::CMD_DIV;
    zdiv   = cmd == mcp_pkg::CMD_DIV && opb[63:0] == 64'h0;
    v65    = '0;
    res    = opa;
    flags  = '0;
    case (cmd)
      mcp_pkg::CMD_ADD: v65 = {opa[63], opa[63:0]} + {opb[63], opb[63:0]};
      mcp_pkg::CMD_SUB: v65 = {opa[63], opa[63:0]} - {opb[63], opb[63:0]};
      mcp_pkg::CMD_DIV: v65 = (opa[63] ^ opb[63]) ? -{1'b0, quo}
                                                  : {1'b0, quo};
      default: ;
    endcase
    // Only integer arithmetic is built; real operands trap as invalid
    if (arith)
    begin
      res                    = {{15{v65[64]}}, v65};
      flags[mcp_pkg::EXC_IE] = ~is_int;
      flags[mcp_pkg::EXC_OE] = is_int & ~fits(v65, fmt);
    end
    if (zdiv)
    begin
      flags[mcp_pkg::EXC_ZE] = 1'b1;
    end
    else if (cmd == mcp_pkg::CMD_DIV)
    begin
      flags[mcp_pkg::EXC_PE] = |rem;
      flags[mcp_pkg::EXC_UE] = ~(|quo) & (|opa[63:0]);
    end
    if (cmd == mcp_pkg::CMD_LOAD)
    begin
      flags[mcp_pkg::EXC_DE] = denorm(opa, fmt);
    end
    flags[mcp_pkg::EXC_IE] = flags[mcp_pkg::EXC_IE] | stk_bad;
  end

endmodule : mcp_alu

`default_nettype wire

/* File: rtl/mcp_host_port.sv */
`default_nettype none

module mcp_host_port (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire mcp_pkg::mcp_io_req_s io_req,
  output logic      [15:0]          io_rdata_r,
  output logic                      io_rvalid_r,
  output logic                      busy_r,
  output logic                      error_r,
  output logic                      irq13_r
);

  // ************************************************************
  // State
  // ************************************************************
  mcp_pkg::mcp_state_e state_r, state_nxt;
  mcp_pkg::mcp_op_s    op_r, op_nxt;
  logic [2:0]  top_r, top_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [5:0]  mask_r, mask_nxt;
  logic [5:0]  stat_r, stat_nxt;
  logic        hold_r, hold_nxt;
  logic [79:0] buf_r, buf_nxt;
  logic [2:0]  wcnt_r, wcnt_nxt;
  logic [79:0] res_r, res_nxt;
  logic [2:0]  ridx_r, ridx_nxt;
  logic [63:0] quo_r, quo_nxt;
  logic [63:0] rem_r, rem_nxt;
  logic [63:0] dvs_r, dvs_nxt;
  logic [6:0]  step_r, step_nxt;
  logic [15:0] rdata_nxt;
  logic        rvalid_nxt, busy_nxt, error_nxt, irq_nxt;

  logic        wr_hit, rd_hit, cmd_wr, opd_wr, clr_busy;
  logic        stk_bad, div_go, fin, err_set, bad, wen;
  logic [2:0]  ra_a, ra_b, waddr;
  logic [79:0] rf_a, rf_b, alu_a, alu_res;
  logic [5:0]  alu_flags;
  logic [64:0] dtmp;

  function automatic logic [79:0] ld_ext(logic [79:0] w,
                                         mcp_pkg::mcp_fmt_e f);
    case (f)
      mcp_pkg::FMT_I16: ld_ext = {{64{w[15]}}, w[15:0]};
      mcp_pkg::FMT_I32: ld_ext = {{48{w[31]}}, w[31:0]};
      mcp_pkg::FMT_I64: ld_ext = {{16{w[63]}}, w[63:0]};
      mcp_pkg::FMT_R24: ld_ext = {48'h0, w[31:0]};
      mcp_pkg::FMT_R53: ld_ext = {16'h0, w[63:0]};
      default:          ld_ext = w;
    endcase
  endfunction : ld_ext

  function automatic logic [63:0] mag(logic [63:0] v);
    mag = v[63] ? -v : v;
  endfunction : mag

  // ************************************************************
  // Port decode
  // ************************************************************
  // Host signals share our clock, so no synchronisers
  always_comb
  begin
    wr_hit   = io_req.strb & io_req.wr;
    rd_hit   = io_req.strb & ~io_req.wr;
    cmd_wr   = wr_hit && io_req.addr == mcp_pkg::PORT_CMD && !busy_r;
    opd_wr   = wr_hit && io_req.addr == mcp_pkg::PORT_OPND && !busy_r;
    clr_busy = wr_hit && io_req.byte8 && io_req.addr == mcp_pkg::PORT_CLR
               && io_req.wdata[7:0] == 8'h00;
  end

  // ************************************************************
  // Operand fetch, stack or fixed addressing
  // ************************************************************
  always_comb
  begin
    ra_a = op_r.fixed ? op_r.ra : top_r;
    ra_b = op_r.fixed ? op_r.rb : top_r + 3'h1;
    case (op_r.cmd)
      mcp_pkg::CMD_LOAD:
        stk_bad = !op_r.fixed && cnt_r == mcp_pkg::NREG_CNT;
      mcp_pkg::CMD_STORE:
        stk_bad = !op_r.fixed && cnt_r == 4'h0;
      mcp_pkg::CMD_ADD, mcp_pkg::CMD_SUB, mcp_pkg::CMD_DIV:
        stk_bad = !op_r.fixed && cnt_r < 4'h2;
      mcp_pkg::CMD_SETMASK, mcp_pkg::CMD_CLEX:
        stk_bad = 1'b0;
      default:
        stk_bad = 1'b1;
    endcase
    alu_a = (op_r.cmd == mcp_pkg::CMD_LOAD) ? ld_ext(buf_r, op_r.fmt)
                                            : rf_a;
  end

  mcp_regfile u_regs (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wen      (wen),
    .waddr    (waddr),
    .wdata    (alu_res),
    .raddr_a  (ra_a),
    .raddr_b  (ra_b),
    .rdata_a  (rf_a),
    .rdata_b  (rf_b)
  );

  mcp_alu u_alu (
    .cmd      (op_r.cmd),
    .fmt      (op_r.fmt),
    .opa      (alu_a),
    .opb      (rf_b),
    .quo      (quo_r),
    .rem      (rem_r),
    .stk_bad  (stk_bad),
    .res      (alu_res),
    .flags    (alu_flags)
  );

  // ************************************************************
  // Sequencer and execution
  // ************************************************************
  always_comb
  begin
    state_nxt = state_r;
    op_nxt    = op_r;
    top_nxt   = top_r;
    cnt_nxt   = cnt_r;
    mask_nxt  = mask_r;
    stat_nxt  = stat_r;
    buf_nxt   = buf_r;
    wcnt_nxt  = wcnt_r;
    res_nxt   = res_r;
    ridx_nxt  = ridx_r;
    quo_nxt   = quo_r;
    rem_nxt   = rem_r;
    dvs_nxt   = dvs_r;
    step_nxt  = step_r;
    wen       = 1'b0;
    waddr     = op_r.ra;
    err_set   = 1'b0;
    dtmp      = {rem_r, quo_r[63]};
    // Nothing is fetched from memory here; the host hands every value in
    if (opd_wr && wcnt_r < mcp_pkg::NWORDS)
    begin
      buf_nxt[wcnt_r*16 +: 16] = io_req.wdata;
      wcnt_nxt                 = wcnt_r + 3'h1;
    end
    div_go = state_r == mcp_pkg::S_OPER && op_r.cmd == mcp_pkg::CMD_DIV &&
             !stk_bad && rf_b[63:0] != 64'h0;
    fin    = (state_r == mcp_pkg::S_OPER && !div_go) ||
             state_r == mcp_pkg::S_FIN;
    bad    = alu_flags[mcp_pkg::EXC_IE] | alu_flags[mcp_pkg::EXC_ZE];
    case (state_r)
      mcp_pkg::S_IDLE:
        if (cmd_wr)
        begin
          op_nxt    = mcp_pkg::mcp_op_s'(io_req.wdata);
          state_nxt = mcp_pkg::S_FETCH;
        end
      mcp_pkg::S_FETCH:
        state_nxt = mcp_pkg::S_OPER;
      mcp_pkg::S_OPER:
        if (div_go)
        begin
          dvs_nxt   = mag(rf_b[63:0]);
          quo_nxt   = mag(rf_a[63:0]);
          rem_nxt   = '0;
          step_nxt  = mcp_pkg::DIV_STEPS;
          state_nxt = mcp_pkg::S_DIV;
        end
        else
        begin
          state_nxt = mcp_pkg::S_IDLE;
        end
      mcp_pkg::S_DIV:
      begin
        // One quotient bit a cycle keeps the divider small
        if (dtmp >= {1'b0, dvs_r})
        begin
          rem_nxt = 64'(dtmp - {1'b0, dvs_r});
        end
        else
        begin
          rem_nxt = dtmp[63:0];
        end
        quo_nxt  = {quo_r[62:0], dtmp >= {1'b0, dvs_r}};
        step_nxt = step_r - 7'h1;
        if (step_r == 7'h1)
        begin
          state_nxt = mcp_pkg::S_FIN;
        end
      end
      default:
        state_nxt = mcp_pkg::S_IDLE;
    endcase
    if (fin)
    begin
      stat_nxt = stat_r | alu_flags;
      err_set  = |(alu_flags & ~mask_r);
      if (!bad)
      begin
        case (op_r.cmd)
          mcp_pkg::CMD_LOAD:
          begin
            wen = 1'b1;
            if (!op_r.fixed)
            begin
              waddr   = top_r - 3'h1;
              top_nxt = top_r - 3'h1;
              cnt_nxt = cnt_r + 4'h1;
            end
          end
          mcp_pkg::CMD_ADD, mcp_pkg::CMD_SUB, mcp_pkg::CMD_DIV:
          begin
            wen = 1'b1;
            if (!op_r.fixed)
            begin
              waddr   = top_r + 3'h1;
              top_nxt = top_r + 3'h1;
              cnt_nxt = cnt_r - 4'h1;
            end
          end
          mcp_pkg::CMD_STORE:
          begin
            res_nxt  = rf_a;
            ridx_nxt = 3'h0;
            if (!op_r.fixed)
            begin
              top_nxt = top_r + 3'h1;
              cnt_nxt = cnt_r - 4'h1;
            end
          end
          mcp_pkg::CMD_SETMASK:
            mask_nxt = buf_r[5:0];
          mcp_pkg::CMD_CLEX:
            stat_nxt = '0;
          default: ;
        endcase
      end
      if (op_r.cmd == mcp_pkg::CMD_LOAD || op_r.cmd == mcp_pkg::CMD_SETMASK)
      begin
        buf_nxt  = '0;
        wcnt_nxt = 3'h0;
      end
    end
    if (rd_hit && io_req.addr == mcp_pkg::PORT_RES)
    begin
      ridx_nxt = (ridx_r == mcp_pkg::NWORDS - 3'h1) ? 3'h0 : ridx_r + 3'h1;
    end
  end

  // ************************************************************
  // Error, interrupt, busy latch and read answer
  // ************************************************************
  always_comb
  begin
    error_nxt = |(stat_nxt & ~mask_nxt);
    // Set wins over a clear in the same cycle
    hold_nxt  = err_set | (error_nxt & ~error_r) |
                (hold_r & ~clr_busy);
    irq_nxt   = err_set | (error_nxt & ~error_r) |
                (irq13_r & ~clr_busy);
    busy_nxt  = state_nxt != mcp_pkg::S_IDLE || hold_nxt;
    rvalid_nxt = 1'b0;
    rdata_nxt  = 16'h0000;
    if (rd_hit && io_req.addr == mcp_pkg::PORT_CMD)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt[5:0] = stat_r;
      rdata_nxt[mcp_pkg::ST_TOP_LSB +: 3] = top_r;
      rdata_nxt[mcp_pkg::ST_CNT_LSB +: 4] = cnt_r;
      rdata_nxt[mcp_pkg::ST_ERR_BIT] = error_r;
      rdata_nxt[mcp_pkg::ST_BSY_BIT] = busy_r;
    end
    else if (rd_hit && io_req.addr == mcp_pkg::PORT_OPND)
    begin
      rvalid_nxt     = 1'b1;
      rdata_nxt[5:0] = mask_r;
    end
    else if (rd_hit && io_req.addr == mcp_pkg::PORT_RES)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = res_r[ridx_r*16 +: 16];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r     <= mcp_pkg::S_IDLE;
      op_r        <= '0;
      top_r       <= '0;
      cnt_r       <= '0;
      mask_r      <= mcp_pkg::MASK_RST;
      stat_r      <= '0;
      hold_r      <= 1'b0;
      buf_r       <= '0;
      wcnt_r      <= '0;
      res_r       <= '0;
      ridx_r      <= '0;
      quo_r       <= '0;
      rem_r       <= '0;
      dvs_r       <= '0;
      step_r      <= '0;
      io_rdata_r  <= '0;
      io_rvalid_r <= 1'b0;
      busy_r      <= 1'b0;
      error_r     <= 1'b0;
      irq13_r     <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      op_r        <= op_nxt;
      top_r       <= top_nxt;
      cnt_r       <= cnt_nxt;
      mask_r      <= mask_nxt;
      stat_r      <= stat_nxt;
      hold_r      <= hold_nxt;
      buf_r       <= buf_nxt;
      wcnt_r      <= wcnt_nxt;
      res_r       <= res_nxt;
      ridx_r      <= ridx_nxt;
      quo_r       <= quo_nxt;
      rem_r       <= rem_nxt;
      dvs_r       <= dvs_nxt;
      step_r      <= step_nxt;
      io_rdata_r  <= rdata_nxt;
      io_rvalid_r <= rvalid_nxt;
      busy_r      <= busy_nxt;
      error_r     <= error_nxt;
      irq13_r     <= irq_nxt;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  busy_exec_a: assert property (
    busy_r == (state_r != mcp_pkg::S_IDLE || hold_r))
    else $error("busy does not follow execution");
  div_busy_a: assert property (
    div_go |=> busy_r [*8])
    else $error("busy dropped during divide");
  err_irq_a: assert property (
    $rose(error_r) |-> irq13_r && hold_r && busy_r)
    else $error("error without irq or busy latch");
  clr_hold_a: assert property (
    clr_busy && !err_set && !(error_nxt && !error_r) |=> !hold_r)
    else $error("busy latch not cleared");
  clr_irq_a: assert property (
    clr_busy && !err_set && !(error_nxt && !error_r) |=> !irq13_r)
    else $error("irq not cleared");
  unmask_err_a: assert property (
    fin && |(alu_flags & ~mask_r) && op_r.cmd != mcp_pkg::CMD_SETMASK
    |=> error_r)
    else $error("unmasked exception without error");
  masked_quiet_a: assert property (
    fin && (alu_flags & ~mask_r) == 6'h0 && !error_r &&
    op_r.cmd != mcp_pkg::CMD_SETMASK |=> !error_r)
    else $error("masked exception raised error");
  zero_div_a: assert property (
    fin && op_r.cmd == mcp_pkg::CMD_DIV && !stk_bad && rf_b[63:0] == 64'h0
    |=> stat_r[mcp_pkg::EXC_ZE])
    else $error("zero divide not flagged");
  push_depth_a: assert property (
    fin && !bad && op_r.cmd == mcp_pkg::CMD_LOAD && !op_r.fixed
    |=> cnt_r == $past(cnt_r) + 4'h1 && top_r == $past(top_r) - 3'h1)
    else $error("stack push miscounted");
  depth_max_a: assert property (
    cnt_r <= mcp_pkg::NREG_CNT)
    else $error("stack depth above eight");
  rst_quiet_a: assert property (
    $rose(rst_n) |-> !hold_r && !irq13_r)
    else $error("latch or irq set out of reset");

  div_done_c: cover property (state_r == mcp_pkg::S_FIN);
  err_clr_c:  cover property (irq13_r ##1 clr_busy ##1 !irq13_r);
  res_read_c: cover property (io_rvalid_r && ridx_r == 3'h4);

endmodule : mcp_host_port

`default_nettype wire

/* File: rtl/mcp_pkg.sv */
// Functional notes
// - Behaviour is the same in every host addressing mode.
// - Only the host touches memory; the block acts on what it is handed.
// - Eight data registers of 80 bits each hold constants and results.
// - Registers are used as a stack (top two only) or as a fixed set.
// - Seven formats: 16/32/64-bit integer, 18-digit BCD, 24/53/64 real.
// - The block runs on the host's own clock, in one clock domain.
// - The block answers I/O cycles at ports 00F8, 00FA and 00FC.
// - Busy stays high while an instruction executes; host then waits.
// - Six exceptions are detected during execution.
// - An unmasked exception drives error; a masked one does not.
// - Error raises interrupt 13 and latches busy high.
// - An 8-bit write of zero to port 00F0 clears the latched busy.
// - The same write also drops interrupt 13.
`default_nettype none

package mcp_pkg;

  // ************************************************************
  // Port map
  // ************************************************************
  localparam logic [15:0] PORT_CLR  = 16'h00F0;
  localparam logic [15:0] PORT_CMD  = 16'h00F8;
  localparam logic [15:0] PORT_OPND = 16'h00FA;
  localparam logic [15:0] PORT_RES  = 16'h00FC;

  // ************************************************************
  // Sizes, reset values, counts
  // ************************************************************
  localparam int          NREG      = 8;
  localparam logic [3:0]  NREG_CNT  = 4'h8;
  localparam logic [2:0]  NWORDS    = 3'h5;
  localparam logic [5:0]  MASK_RST  = 6'h3F;
  localparam logic [6:0]  DIV_STEPS = 7'h40;

  // ************************************************************
  // Exception flag positions
  // ************************************************************
  localparam int EXC_IE = 0;
  localparam int EXC_DE = 1;
  localparam int EXC_ZE = 2;
  localparam int EXC_OE = 3;
  localparam int EXC_UE = 4;
  localparam int EXC_PE = 5;

  // ************************************************************
  // Status word field positions
  // ************************************************************
  localparam int ST_TOP_LSB = 6;
  localparam int ST_CNT_LSB = 9;
  localparam int ST_ERR_BIT = 13;
  localparam int ST_BSY_BIT = 14;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    CMD_LOAD, CMD_STORE, CMD_ADD, CMD_SUB, CMD_DIV, CMD_SETMASK, CMD_CLEX
  } mcp_cmd_e;

  typedef enum logic [2:0] {
    FMT_I16, FMT_I32, FMT_I64, FMT_BCD, FMT_R24, FMT_R53, FMT_R64
  } mcp_fmt_e;

  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_OPER, S_DIV, S_FIN
  } mcp_state_e;

  typedef struct packed {
    logic        strb;
    logic        wr;
    logic        byte8;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mcp_io_req_s;

  typedef struct packed {
    mcp_cmd_e   cmd;
    mcp_fmt_e   fmt;
    logic       fixed;
    logic [1:0] rsvd;
    logic [2:0] ra;
    logic [2:0] rb;
  } mcp_op_s;

endpackage : mcp_pkg

`default_nettype wire

/* File: rtl/mcp_regfile.sv */
`default_nettype none

module mcp_regfile (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wen,
  input  wire logic [2:0]  waddr,
  input  wire logic [79:0] wdata,
  input  wire logic [2:0]  raddr_a,
  input  wire logic [2:0]  raddr_b,
  output logic      [79:0] rdata_a,
  output logic      [79:0] rdata_b
);

  // ************************************************************
  // Eight 80-bit data registers
  // ************************************************************
  logic [79:0] mem_r [mcp_pkg::NREG];
  logic [79:0] rda_nxt;
  logic [79:0] rdb_nxt;

  // No reset on the array; contents are undefined until loaded
  always_ff @(posedge core_clk)
  begin
    if (wen)
    begin
      mem_r[waddr] <= wdata;
    end
  end

  always_comb
  begin
    rda_nxt = mem_r[raddr_a];
    rdb_nxt = mem_r[raddr_b];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_a <= '0;
      rdata_b <= '0;
    end
    else
    begin
      rdata_a <= rda_nxt;
      rdata_b <= rdb_nxt;
    end
  end

endmodule : mcp_regfile

`default_nettype wire
